// >>> rtl/tfp_pkg.sv
// Constants for the 16-bit PWM waveform generator: map, fields, modes, resets
package tfp_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CMP_A   = 8'h04;
  localparam logic [7:0] ADDR_CMP_B   = 8'h08;
  localparam logic [7:0] ADDR_CAP_TOP = 8'h0C;
  localparam logic [7:0] ADDR_COUNT   = 8'h10;
  localparam logic [7:0] ADDR_FLAGS   = 8'h14;
  // Control fields
  localparam int MODE_LSB  = 0;
  localparam int ACT_A_LSB = 4;
  localparam int ACT_B_LSB = 6;
  localparam int DIR_A_BIT = 8;
  localparam int DIR_B_BIT = 9;
  localparam logic [9:0] CTRL_WMASK = 10'h3FF;
  // Flag bits
  localparam int FLAG_OVF   = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int FLAG_CAP   = 3;
  // Reset values
  localparam logic [9:0]  CTRL_RESET  = 10'h000;
  localparam logic [15:0] CMP_RESET   = 16'h0000;
  localparam logic [15:0] CAP_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [3:0]  FLAGS_RESET = 4'h0;
  // Waveform mode select values
  localparam logic [3:0] MODE_PC8       = 4'h1;
  localparam logic [3:0] MODE_PC9       = 4'h2;
  localparam logic [3:0] MODE_PC10      = 4'h3;
  localparam logic [3:0] MODE_FAST8     = 4'h5;
  localparam logic [3:0] MODE_FAST9     = 4'h6;
  localparam logic [3:0] MODE_FAST10    = 4'h7;
  localparam logic [3:0] MODE_PC_CAP    = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA   = 4'hB;
  localparam logic [3:0] MODE_FAST_CAP  = 4'hE;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;
  // Output action select values
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV    = 2'h3;
  // Fixed TOP values
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_FULL  = 16'hFFFF;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/tfp_waveform_gen.sv
// Fast and phase correct PWM waveform generator with AXI4-Lite registers
//
// Functional notes
// - Mode values 5, 6, 7, 14, 15 select single-slope fast PWM.
// - Fast PWM counts up from zero to TOP, then restarts at zero.
// - Fast non-inverting: clear output on match, set when counter returns to zero.
// - Fast inverting: set output on match, clear when counter returns to zero.
// - Output action two selects non-inverting, three selects inverting.
// - Fast TOP is 0x00FF, 0x01FF, 0x03FF, capture register, or compare A.
// - Fast PWM counter at TOP clears to zero next timer cycle.
// - Fast overflow flag at TOP; capture or compare A flag with it.
// - Compare flag set whenever counter matches channel compare value, if that value is not above TOP.
// - Fixed TOP masks unused high bits of written compare values.
// - Capture TOP is unbuffered; written below count, counter wraps through 0xFFFF.
// - Compare A writes go to a buffer register in fast PWM.
// - Fast PWM loads active compares from buffers when counter matches TOP.
// - Compare zero gives one-cycle spike; compare equal TOP gives constant level.
// - Mode 15 with action 1 toggles output A on match.
// - Mode values 1, 2, 3, 10, 11 select phase correct up-down counting.
// - Phase correct TOP is 0x00FF, 0x01FF, 0x03FF, capture, or compare A.
// - Phase correct non-inverting clears on up match, sets on down match.
// - Phase correct holds TOP one timer cycle, then counts down.
// - Compare output always reaches its pin; its output enable is set only while its direction bit selects output and its action is not zero.
// - Phase correct overflow flag is set at zero, not at TOP.
// - Phase correct loads compares at TOP; TOP register flag set then.
// - Reset forces every internal compare output to zero.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tfp_waveform_gen #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enables
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              clkEn,
  input  wire logic              timerTick,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Compare output pins, index 0 is channel A
  output logic [1:0]             compareOutputPin,
  output logic [1:0]             compareOutputOe
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [9:0]        ctrl_q;
  logic [15:0]       cmpBuf_q [2];
  logic [15:0]       cmpAct_q [2];
  logic [15:0]       captureTop_q;
  logic [15:0]       countValue_q;
  logic              dirUp_q;
  logic [3:0]        flags_q;
  logic              awHeld_q;
  logic              wHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic isFastMode(input logic [3:0] m);
    return m == tfp_pkg::MODE_FAST8 || m == tfp_pkg::MODE_FAST9 ||
           m == tfp_pkg::MODE_FAST10 || m == tfp_pkg::MODE_FAST_CAP ||
           m == tfp_pkg::MODE_FAST_CMPA;
  endfunction

  function automatic logic isPcMode(input logic [3:0] m);
    return m == tfp_pkg::MODE_PC8 || m == tfp_pkg::MODE_PC9 ||
           m == tfp_pkg::MODE_PC10 || m == tfp_pkg::MODE_PC_CAP ||
           m == tfp_pkg::MODE_PC_CMPA;
  endfunction

  // Fixed TOP for 8/9/10-bit modes, full width otherwise
  function automatic logic [15:0] fixedTop(input logic [3:0] m);
    case (m)
      tfp_pkg::MODE_FAST8,  tfp_pkg::MODE_PC8:  return tfp_pkg::TOP_8BIT;
      tfp_pkg::MODE_FAST9,  tfp_pkg::MODE_PC9:  return tfp_pkg::TOP_9BIT;
      tfp_pkg::MODE_FAST10, tfp_pkg::MODE_PC10: return tfp_pkg::TOP_10BIT;
      default:                                  return tfp_pkg::TOP_FULL;
    endcase
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return a[7:0] == tfp_pkg::ADDR_CTRL || a[7:0] == tfp_pkg::ADDR_CMP_A ||
           a[7:0] == tfp_pkg::ADDR_CMP_B || a[7:0] == tfp_pkg::ADDR_CAP_TOP ||
           a[7:0] == tfp_pkg::ADDR_COUNT || a[7:0] == tfp_pkg::ADDR_FLAGS;
  endfunction

  function automatic logic [31:0] readMux(input logic [ADDR_W-1:0] a);
    case (a[7:0])
      tfp_pkg::ADDR_CTRL:    return {22'h000000, ctrl_q};
      tfp_pkg::ADDR_CMP_A:   return {16'h0000, cmpBuf_q[0]};
      tfp_pkg::ADDR_CMP_B:   return {16'h0000, cmpBuf_q[1]};
      tfp_pkg::ADDR_CAP_TOP: return {16'h0000, captureTop_q};
      tfp_pkg::ADDR_COUNT:   return {16'h0000, countValue_q};
      tfp_pkg::ADDR_FLAGS:   return {28'h0000000, flags_q};
      default:               return 32'h00000000;
    endcase
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode, TOP and events
  logic [3:0]  waveformModeSelect;
  logic        fastMode;
  logic        pcMode;
  logic [15:0] topValue;
  logic        tick;
  logic        atTop;
  logic        wrapEvt;
  logic        pcTopEvt;
  logic        bottomEvt;
  logic        loadEvt;
  logic [1:0]  match;

  assign waveformModeSelect = ctrl_q[tfp_pkg::MODE_LSB +: 4];
  assign fastMode  = isFastMode(waveformModeSelect);
  assign pcMode    = isPcMode(waveformModeSelect);
  assign tick      = clkEn && timerTick;

  always_comb
  begin
    case (waveformModeSelect)
      tfp_pkg::MODE_FAST_CAP,  tfp_pkg::MODE_PC_CAP:  topValue = captureTop_q;
      tfp_pkg::MODE_FAST_CMPA, tfp_pkg::MODE_PC_CMPA: topValue = cmpAct_q[0];
      default:                                        topValue = fixedTop(waveformModeSelect);
    endcase
  end

  assign atTop     = countValue_q == topValue;
  assign wrapEvt   = tick && fastMode && atTop;
  assign pcTopEvt  = tick && pcMode && dirUp_q && atTop;
  assign bottomEvt = tick && pcMode && !dirUp_q && countValue_q == 16'h0000;
  assign loadEvt   = wrapEvt || pcTopEvt;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        writeGo;
  logic [31:0] wrMerged;

  assign awready  = clkEn && !awHeld_q && !bvalid_q;
  assign wready   = clkEn && !wHeld_q && !bvalid_q;
  assign arready  = clkEn && !rvalid_q;
  assign writeGo  = clkEn && awHeld_q && wHeld_q && !bvalid_q;
  // Process form so register reads inside the mux wake the merge as well
  always_comb
  begin
    wrMerged = mergeStrb(readMux(awAddr_q), wData_q, wStrb_q);
  end

  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign rvalid   = rvalid_q;
  assign rdata    = rdata_q;
  assign rresp    = rresp_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= tfp_pkg::RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (awvalid && awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (writeGo)
      begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= isMapped(awAddr_q) ? tfp_pkg::RESP_OKAY : tfp_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= tfp_pkg::RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (arvalid && arready)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= readMux(araddr);
        rresp_q  <= isMapped(araddr) ? tfp_pkg::RESP_OKAY : tfp_pkg::RESP_SLVERR;
      end
      else if (rvalid_q && rready)
        rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_q       <= tfp_pkg::CTRL_RESET;
      cmpBuf_q[0]  <= tfp_pkg::CMP_RESET;
      cmpBuf_q[1]  <= tfp_pkg::CMP_RESET;
      captureTop_q <= tfp_pkg::CAP_RESET;
    end
    else if (writeGo)
    begin
      case (awAddr_q[7:0])
        tfp_pkg::ADDR_CTRL:    ctrl_q <= wrMerged[9:0] & tfp_pkg::CTRL_WMASK;
        // Writes land in the buffer, never the active compare
        tfp_pkg::ADDR_CMP_A:   cmpBuf_q[0] <= wrMerged[15:0] & fixedTop(waveformModeSelect);
        tfp_pkg::ADDR_CMP_B:   cmpBuf_q[1] <= wrMerged[15:0] & fixedTop(waveformModeSelect);
        tfp_pkg::ADDR_CAP_TOP: captureTop_q <= wrMerged[15:0];
        default:               ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active compare registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cmpAct_q[0] <= tfp_pkg::CMP_RESET;
      cmpAct_q[1] <= tfp_pkg::CMP_RESET;
    end
    else if (loadEvt || (clkEn && !fastMode && !pcMode))
    begin
      cmpAct_q[0] <= cmpBuf_q[0];
      cmpAct_q[1] <= cmpBuf_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and direction
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      countValue_q <= tfp_pkg::COUNT_RESET;
      dirUp_q      <= 1'b1;
    end
    else if (tick)
    begin
      if (fastMode)
      begin
        dirUp_q <= 1'b1;
        // Unbuffered TOP below count runs on through 0xFFFF
        if (atTop)
          countValue_q <= 16'h0000;
        else
          countValue_q <= countValue_q + 16'h0001;
      end
      else if (pcMode)
      begin
        if (pcTopEvt)
        begin
          dirUp_q      <= 1'b0;
          countValue_q <= countValue_q - 16'h0001;
        end
        else if (bottomEvt)
        begin
          dirUp_q      <= 1'b1;
          countValue_q <= 16'h0001;
        end
        else if (dirUp_q)
          countValue_q <= countValue_q + 16'h0001;
        else
          countValue_q <= countValue_q - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, write one to clear; a same-cycle set wins
  logic [3:0] flagSet;
  logic [3:0] flagClr;

  always_comb
  begin
    flagSet = 4'h0;
    flagSet[tfp_pkg::FLAG_OVF]   = wrapEvt || bottomEvt;
    flagSet[tfp_pkg::FLAG_CMP_A] = match[0] ||
      (loadEvt && waveformModeSelect[1:0] == 2'h3 && waveformModeSelect[3]);
    flagSet[tfp_pkg::FLAG_CMP_B] = match[1];
    flagSet[tfp_pkg::FLAG_CAP]   = loadEvt && (waveformModeSelect == tfp_pkg::MODE_FAST_CAP ||
                                   waveformModeSelect == tfp_pkg::MODE_PC_CAP);
    flagClr = 4'h0;
    if (writeGo && awAddr_q[7:0] == tfp_pkg::ADDR_FLAGS)
      flagClr = wrMerged[3:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      flags_q <= tfp_pkg::FLAGS_RESET;
    else if (clkEn)
      flags_q <= (flags_q & ~flagClr) | flagSet;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare output units
  logic upPhase;

  // The TOP cycle counts as down slope, the zero cycle as up slope
  assign upPhase = (dirUp_q && !atTop) || countValue_q == 16'h0000;

  for (genvar i = 0; i < 2; i++)
  begin : gChan
    logic [1:0] act;
    logic       dirBit;
    logic       toggleOk;
    logic       oc_q;

    assign act      = ctrl_q[(i == 0 ? tfp_pkg::ACT_A_LSB : tfp_pkg::ACT_B_LSB) +: 2];
    assign dirBit   = ctrl_q[i == 0 ? tfp_pkg::DIR_A_BIT : tfp_pkg::DIR_B_BIT];
    assign toggleOk = (i == 0) && act == tfp_pkg::ACT_TOGGLE &&
                      (waveformModeSelect == tfp_pkg::MODE_FAST_CMPA ||
                       waveformModeSelect == tfp_pkg::MODE_PC_CMPA);
    assign match[i] = tick && (fastMode || pcMode) && countValue_q == cmpAct_q[i] &&
                      cmpAct_q[i] <= topValue;

    always_ff @(posedge clk)
    begin
      if (reset)
        oc_q <= 1'b0;
      else if (toggleOk && match[i])
        oc_q <= !oc_q;
      else if (act[1] && fastMode && wrapEvt)
        oc_q <= act == tfp_pkg::ACT_NONINV;
      else if (act[1] && fastMode && match[i])
        oc_q <= act == tfp_pkg::ACT_INV;
      else if (act[1] && pcMode && match[i])
        oc_q <= upPhase ? act == tfp_pkg::ACT_INV : act == tfp_pkg::ACT_NONINV;
    end

    assign compareOutputPin[i] = oc_q;
    assign compareOutputOe[i]  = dirBit && act != 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_fastTop;
    fastMode && tick && atTop;
  endsequence

  sequence s_pcTurn;
    pcMode && tick && dirUp_q && atTop;
  endsequence

  a_fast_wrap_zero: assert property (s_fastTop |=> countValue_q == 16'h0000)
    else $error("Fast counter did not clear after TOP");
  a_fast_count_up: assert property (fastMode && tick && !atTop |=>
                                    countValue_q == $past(countValue_q) + 16'h0001)
    else $error("Fast counter did not increment");
  a_fast_ovf_flag: assert property (s_fastTop |=> flags_q[tfp_pkg::FLAG_OVF])
    else $error("Overflow flag missing at fast TOP");
  a_fast_buf_load: assert property (s_fastTop |=> cmpAct_q[1] == $past(cmpBuf_q[1]))
    else $error("Compare buffer not loaded at TOP");
  a_pc_turn_down: assert property (s_pcTurn |=> !dirUp_q &&
                                   countValue_q == $past(countValue_q) - 16'h0001)
    else $error("Phase correct counter did not turn at TOP");
  a_pc_ovf_bottom: assert property (bottomEvt |=> flags_q[tfp_pkg::FLAG_OVF] &&
                                    countValue_q == 16'h0001)
    else $error("Overflow flag missing at bottom");
  a_pc_no_top_ovf: assert property ((s_pcTurn and !flags_q[tfp_pkg::FLAG_OVF]) |=>
                                    !flags_q[tfp_pkg::FLAG_OVF])
    else $error("Overflow flag set at phase correct TOP");
  a_cmp_flag_set: assert property (match[1] |=> flags_q[tfp_pkg::FLAG_CMP_B])
    else $error("Compare flag missing on match");
  a_noninv_clear: assert property (fastMode && gChan[1].act == tfp_pkg::ACT_NONINV &&
                                   match[1] && !wrapEvt |=> !compareOutputPin[1])
    else $error("Non-inverting output not cleared on match");
  a_pin_dir_gate: assert property (!ctrl_q[tfp_pkg::DIR_B_BIT] |-> !compareOutputOe[1])
    else $error("Pin driven while direction is input");
  a_reset_outputs: assert property (disable iff (1'b0) reset |=> compareOutputPin == 2'b00)
    else $error("Compare outputs not zero after reset");

endmodule

// >>> sim/tb.sv
// Self-checking bench for the fast and phase correct PWM waveform generator
`timescale 1ns/1ps
module tb;
  logic        clk, reset, clkEn, timerTick, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, dir;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, pin, oe, rs, aA, aB, outs;
  logic [15:0] c, cap, actA, actB, bufA, bufB;
  logic [3:0]  mode, flg;
  logic [3:0]  shortModes [4] = '{4'h6, 4'h7, 4'h2, 4'h3};
  int          failures, num_checks, cyc;

  tfp_waveform_gen u_tfp_waveform_gen (
    .clk(clk), .reset(reset), .clkEn(clkEn), .timerTick(timerTick),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .compareOutputPin(pin), .compareOutputOe(oe)
  );

  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      failures++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic axWr(input logic [7:0] a, input logic [31:0] d);
    logic aOk, wOk, bOk;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do
    begin
      @(negedge clk);
      aOk = awvalid && awready;
      wOk = wvalid && wready;
      @(posedge clk);
      if (aOk) awvalid <= 0;
      if (wOk) wvalid <= 0;
    end
    while (awvalid || wvalid);
    bready <= 1;
    do
    begin
      @(negedge clk);
      bOk = bvalid;
      rs = bresp;
      @(posedge clk);
    end
    while (!bOk);
    bready <= 0;
  endtask

  task automatic axRd(input logic [7:0] a);
    logic ok;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    do
    begin
      @(negedge clk);
      ok = arvalid && arready;
      @(posedge clk);
    end
    while (!ok);
    arvalid <= 0;
    rready <= 1;
    do
    begin
      @(negedge clk);
      ok = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
    end
    while (!ok);
    rready <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] topOf();
    case (mode)
      4'h1, 4'h5: return tfp_pkg::TOP_8BIT;
      4'h2, 4'h6: return tfp_pkg::TOP_9BIT;
      4'h3, 4'h7: return tfp_pkg::TOP_10BIT;
      4'hA, 4'hE: return cap;
      default:    return actA;
    endcase
  endfunction

  task automatic modelStep();
    logic [15:0] t, cmp;
    logic [1:0]  ac;
    logic        m, up, fast;
    int          ch;
    t = topOf();
    fast = mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
    up = (c == t) ? 1'b0 : (c == 0) ? 1'b1 : dir;
    for (ch = 0; ch < 2; ch++)
    begin
      cmp = ch ? actB : actA;
      ac = ch ? aB : aA;
      m = c == cmp && cmp <= t;
      if (m) flg[1 + ch] = 1;
      if (m && ac == 2'h1 && ch == 0 && mode[3] && mode[1:0] == 2'h3) outs[0] = ~outs[0];
      else if (ac[1] && fast && c == t) outs[ch] = ~ac[0];
      else if (ac[1] && m) outs[ch] = (fast || up) ? ac[0] : ~ac[0];
    end
    if (c == t)
    begin
      if (mode[3] && mode[1]) flg[mode[0] ? 1 : 3] = 1;
      actA = bufA;
      actB = bufB;
      if (fast) flg[0] = 1;
      dir = fast;
      c = fast ? 16'h0000 : t - 16'h0001;
    end
    else if (!fast && c == 0 && !dir)
    begin
      flg[0] = 1;
      dir = 1;
      c = 16'h0001;
    end
    else
      c = (dir || fast) ? c + 16'h0001 : c - 16'h0001;
  endtask

  task automatic step();
    @(posedge clk);
    timerTick <= 1;
    clkEn <= 0;
    @(posedge clk);
    clkEn <= 1;
    @(posedge clk);
    timerTick <= 0;
    modelStep();
    axRd(tfp_pkg::ADDR_COUNT);
    check("count", rd, {16'h0000, c});
    axRd(tfp_pkg::ADDR_FLAGS);
    check("flags", rd, {28'h0, flg});
    check("pins", {30'h0, pin}, {30'h0, outs});
  endtask

  task automatic runCfg(input logic [3:0] md, input logic [15:0] cp, input logic [15:0] a,
                        input logic [15:0] b, input logic [1:0] xa, input logic [1:0] xb,
                        input int n, input logic da);
    @(posedge clk);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    {c, dir, flg, outs, mode, aA, aB} = {16'h0, 1'b1, 4'h0, 2'h0, md, xa, xb};
    {bufA, actA, bufB, actB, cap} = {a, a, b, b, cp};
    @(negedge clk);
    check("pinsReset", {28'h0, oe, pin}, 32'h0);
    axWr(tfp_pkg::ADDR_CMP_A, {16'h0, a});
    axWr(tfp_pkg::ADDR_CMP_B, {16'h0, b});
    axWr(tfp_pkg::ADDR_CAP_TOP, {16'h0, cp});
    axWr(tfp_pkg::ADDR_CTRL, {22'h0, 1'b1, da, xb, xa, md});
    check("bresp", {30'h0, rs}, {30'h0, tfp_pkg::RESP_OKAY});
    check("oe", {30'h0, oe}, {30'h0, xb != 2'h0, da && xa != 2'h0});
    if (!md[3])
    begin
      bufA = 16'($urandom);
      axWr(tfp_pkg::ADDR_CMP_A, {16'h0, bufA});
      bufA &= topOf();
      axRd(tfp_pkg::ADDR_CMP_A);
      check("cmpBuffer", rd, {16'h0, bufA});
    end
    repeat (n) step();
    if (md == 4'hE)
    begin
      cap = 16'h0003;
      axWr(tfp_pkg::ADDR_CAP_TOP, 32'h3);
      repeat (4) step();
    end
    axWr(tfp_pkg::ADDR_FLAGS, 32'hF);
    axRd(tfp_pkg::ADDR_FLAGS);
    check("flagsClear", rd, 32'h0);
    $display("test mode %0d done", md);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reset, clkEn, timerTick, awvalid, wvalid, bready, arvalid, rready} = 8'h C0;
    {awaddr, araddr, wdata, failures, num_checks, cyc} = '0;
    void'($urandom(82));
    repeat (16) @(posedge clk);
    reset <= 0;
    for (int i = 0; i < 6; i++)
    begin
      axRd(8'(i * 4));
      check("resetValue", {rd[29:0], rs}, 32'h0);
    end
    axRd(8'h18);
    check("unmapped", {rd[29:0], rs}, {30'h0, tfp_pkg::RESP_SLVERR});
    axWr(8'h18, 32'h0);
    check("unmappedWr", {30'h0, rs}, {30'h0, tfp_pkg::RESP_SLVERR});
    runCfg(4'hE, 16'h7, 16'h3, 16'h9, 2'h2, 2'h3, 20, 1);
    runCfg(4'hF, 16'h0, 16'h5, 16'h2, 2'h1, 2'h2, 18, 1);
    runCfg(4'hA, 16'h6, 16'h0, 16'h6, 2'h2, 2'h3, 30, 0);
    runCfg(4'hB, 16'h0, 16'h4, 16'($urandom % 5), 2'h1, 2'h3, 24, 1);
    runCfg(4'h5, 16'h0, 16'h0, 16'($urandom % 256), 2'h3, 2'h2, 520, 1);
    runCfg(4'h1, 16'h0, 16'($urandom % 256), 16'hFF, 2'h2, 2'h3, 520, 1);
    foreach (shortModes[i])
      runCfg(shortModes[i], 16'h0, 16'($urandom), 16'($urandom), 2'h2, 2'h3, 12, 1);
    summarize();
  end
endmodule
